// ### core/sanitize_pkg.sv
// Behaviour
// - sanitize opcode with freeze feature moves the state machine from idle or succeeded to frozen.
// - after freeze completes, every sanitize command except status query aborts.
// - frozen returns to idle only on power-on or hardware reset.
// - count bit 15 shows succeeded entered; it survives power-on reset.
// - count bit 14 set while a sanitize operation runs, else clear.
// - count bit 13 set while the state machine is frozen.
// - progress numerator over 65536: high byte cylinder-low, low byte sector-number.
// - progress reads all ones whenever no operation is running.
// - error reason in sector-number: 00h, 01h, 02h, 03h; others reserved.
// - status query is accepted and executed in every sanitize state.
// - status answer gives progress, success or failure, frozen indication.
// - failed state, failure-mode set, clear bit set: status query returns to idle.
// - failed state, clear bit set but failure-mode was clear: status query is aborted.
package sanitize_pkg;
  localparam logic [7:0]  SANITIZE_OPCODE      = 8'hB4;
  localparam logic [15:0] FEAT_STATUS          = 16'h0000;
  localparam logic [15:0] FEAT_FREEZE_LOCK     = 16'h0020;
  localparam int          CNT_CLEAR_FAILED_BIT = 0;
  localparam int          CNT_FAIL_MODE_BIT    = 4;
  localparam int          CNT_SUCCEEDED_BIT    = 15;
  localparam int          CNT_RUNNING_BIT      = 14;
  localparam int          CNT_FROZEN_BIT       = 13;
  localparam logic [15:0] PROGRESS_IDLE        = 16'hFFFF;
  localparam logic [7:0]  REASON_NONE          = 8'h00;
  localparam logic [7:0]  REASON_UNSANITIZED   = 8'h01;
  localparam logic [7:0]  REASON_BAD_FEATURE   = 8'h02;
  localparam logic [7:0]  REASON_FROZEN        = 8'h03;
  localparam int          ERR_ABORT_BIT        = 2;
  localparam int          ST_BUSY_BIT          = 7;
  localparam int          ST_READY_BIT         = 6;
  localparam int          ST_FAULT_BIT         = 5;
  localparam int          ST_SEEK_DONE_BIT     = 4;
  localparam int          ST_CORRECTED_BIT     = 2;
  localparam int          ST_ERROR_BIT         = 0;
  localparam logic [7:0]  ERR_RESET            = 8'h00;
  localparam logic [7:0]  STAT_RESET           = 8'h50;

  typedef enum logic [2:0] {
    sanitize_idle_state,
    sanitize_frozen_state,
    sanitize_running_state,
    sanitize_failed_state,
    sanitize_succeeded_state
  } sanitize_state_t;
endpackage

// ### core/completion_flag_keep.sv
`timescale 1ns/100ps
// retained flag: the retention init or clr_i clears it, not the system reset
module completion_flag_keep (
  input  wire logic clk_i,
  input  wire logic keep_init_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  always_ff @(posedge clk_i) begin
    if (keep_init_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule

// ### core/sanitize_cmd_ctrl.sv
`timescale 1ns/100ps
module sanitize_cmd_ctrl
  import sanitize_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hw_rst_i,
  input  wire logic        keep_init_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_opcode_i,
  input  wire logic [15:0] cmd_feature_i,
  input  wire logic [15:0] cmd_count_i,
  input  wire logic        op_begin_i,
  input  wire logic        op_fail_mode_i,
  input  wire logic        op_end_i,
  input  wire logic        op_ok_i,
  input  wire logic [15:0] op_progress_i,
  output logic             done_o,
  output logic [7:0]       command_error_flags_o,
  output logic [7:0]       device_status_flags_o,
  output logic [15:0]      count_out_o,
  output logic [7:0]       secnum_out_o,
  output logic [7:0]       cyllow_out_o,
  output logic             frozen_o
);

  function automatic logic [7:0] status_byte(input logic err);
    logic [7:0] s;
    s = 8'h00;
    s[ST_READY_BIT]     = 1'b1;
    s[ST_SEEK_DONE_BIT] = 1'b1;
    s[ST_ERROR_BIT]     = err;
    return s;
  endfunction

  sanitize_state_t state_r;
  sanitize_state_t state_nxt;
  logic            fail_mode_r;
  logic            succeeded_flag;
  logic            done_r;
  logic [7:0]      err_r;
  logic [7:0]      stat_r;
  logic [15:0]     count_r;
  logic [7:0]      secnum_r;
  logic [7:0]      cyllow_r;

  wire take_cmd     = cmd_valid_i && (cmd_opcode_i == SANITIZE_OPCODE);
  wire is_status    = (cmd_feature_i == FEAT_STATUS);
  wire is_freeze    = (cmd_feature_i == FEAT_FREEZE_LOCK);
  wire in_idle      = (state_r == sanitize_idle_state);
  wire in_frozen    = (state_r == sanitize_frozen_state);
  wire in_running   = (state_r == sanitize_running_state);
  wire in_failed    = (state_r == sanitize_failed_state);
  wire in_succeeded = (state_r == sanitize_succeeded_state);
  wire clear_req    = cmd_count_i[CNT_CLEAR_FAILED_BIT];

  // status query never refused by state
  wire status_cmd   = take_cmd && is_status;
  wire clear_ok     = status_cmd && clear_req && in_failed && fail_mode_r;
  wire clear_abort  = status_cmd && clear_req && in_failed && !fail_mode_r;
  wire freeze_cmd   = take_cmd && is_freeze;
  wire freeze_abort = freeze_cmd && (in_frozen || in_running || in_failed);
  wire freeze_ok    = freeze_cmd && !freeze_abort;
  wire other_cmd    = take_cmd && !is_status && !is_freeze;
  wire do_abort     = clear_abort || freeze_abort || other_cmd;
  // freeze outranks a start in the same cycle, so the start must not clear bit 15
  wire op_may_begin = op_begin_i && (in_idle || in_succeeded) && !freeze_ok;
  wire op_finish    = op_end_i && in_running;

  wire [7:0] reason_nxt = in_frozen   ? REASON_FROZEN :
                          clear_abort ? REASON_UNSANITIZED :
                          other_cmd   ? REASON_BAD_FEATURE :
                                        REASON_NONE;

  // progress only while running, all ones otherwise
  wire [15:0] progress_nxt = in_running ? op_progress_i : PROGRESS_IDLE;

  wire [15:0] count_nxt = {succeeded_flag, in_running, in_frozen, 13'h0000};

  wire [7:0] err_nxt = do_abort ? (8'h01 << ERR_ABORT_BIT) : ERR_RESET;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sanitize_idle_state, sanitize_succeeded_state: begin
        if (freeze_ok) begin
          state_nxt = sanitize_frozen_state;
        end else if (op_may_begin) begin
          state_nxt = sanitize_running_state;
        end
      end
      sanitize_frozen_state: begin
        if (hw_rst_i) begin
          state_nxt = sanitize_idle_state;
        end
      end
      sanitize_running_state: begin
        if (op_finish) begin
          state_nxt = op_ok_i ? sanitize_succeeded_state : sanitize_failed_state;
        end
      end
      sanitize_failed_state: begin
        if (clear_ok) begin
          state_nxt = sanitize_idle_state;
        end
      end
      default: state_nxt = sanitize_idle_state;
    endcase
  end

  // power-on reset also clears frozen
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r     <= sanitize_idle_state;
      fail_mode_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (op_may_begin) begin
        fail_mode_r <= op_fail_mode_i;
      end
    end
  end

  completion_flag_keep completion_flag_keep_inst (
    .clk_i       (clk_i),
    .keep_init_i (keep_init_i),
    .set_i       (op_finish && op_ok_i),
    .clr_i       (op_may_begin),
    .flag_o      (succeeded_flag)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_r   <= 1'b0;
      err_r    <= ERR_RESET;
      stat_r   <= STAT_RESET;
      count_r  <= 16'h0000;
      secnum_r <= 8'h00;
      cyllow_r <= 8'h00;
    end else begin
      done_r <= take_cmd;
      if (take_cmd) begin
        err_r    <= err_nxt;
        stat_r   <= status_byte(do_abort);
        count_r  <= count_nxt;
        cyllow_r <= progress_nxt[15:8];
        secnum_r <= do_abort ? reason_nxt : progress_nxt[7:0];
      end
    end
  end

  logic frozen_r;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      frozen_r <= 1'b0;
    end else begin
      frozen_r <= (state_nxt == sanitize_frozen_state);
    end
  end

  assign done_o                = done_r;
  assign command_error_flags_o = err_r;
  assign device_status_flags_o = stat_r;
  assign count_out_o           = count_r;
  assign secnum_out_o          = secnum_r;
  assign cyllow_out_o          = cyllow_r;
  assign frozen_o              = frozen_r;

  chk_freeze_enters_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    freeze_cmd && (in_idle || in_succeeded) && !hw_rst_i |=> in_frozen && frozen_o
      && done_o && !command_error_flags_o[ERR_ABORT_BIT])
    else $error("freeze lock did not enter frozen");

  chk_frozen_aborts_cmds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    in_frozen && take_cmd && !is_status |=> done_o && command_error_flags_o[ERR_ABORT_BIT]
      && secnum_out_o == REASON_FROZEN)
    else $error("command in frozen state not aborted");

  chk_frozen_exit_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    in_frozen |=> (in_frozen != $past(hw_rst_i)) && (in_idle == $past(hw_rst_i)))
    else $error("frozen state left without reset or kept through reset");

  chk_succeeded_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_cmd && (in_succeeded || in_running) |=> count_out_o[CNT_SUCCEEDED_BIT]
      == $past(in_succeeded))
    else $error("completion bit does not match result");

  chk_running_frozen_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_cmd |=> count_out_o[CNT_RUNNING_BIT] == $past(in_running)
      && count_out_o[CNT_FROZEN_BIT] == $past(in_frozen))
    else $error("running or frozen bit wrong");

  chk_progress_value: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    status_cmd && in_running |=> {cyllow_out_o, secnum_out_o} == $past(op_progress_i))
    else $error("progress value not returned");

  chk_progress_all_ones: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    status_cmd && !in_running && !clear_abort |=> {cyllow_out_o, secnum_out_o}
      == PROGRESS_IDLE)
    else $error("progress not all ones outside running");

  chk_bad_feature_reason: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    other_cmd && !in_frozen |=> secnum_out_o == REASON_BAD_FEATURE)
    else $error("unsupported feature reason wrong");

  chk_status_any_state: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    status_cmd && !clear_req |=> done_o && !command_error_flags_o[ERR_ABORT_BIT])
    else $error("status query refused");

  chk_clear_failed_ok: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    in_failed && fail_mode_r && status_cmd && clear_req |=> in_idle ##1 in_idle || in_running
      || in_frozen)
    else $error("failed state not cleared");

  chk_clear_failed_abort: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    in_failed && !fail_mode_r && status_cmd && clear_req |=> in_failed
      && command_error_flags_o[ERR_ABORT_BIT] && device_status_flags_o[ST_ERROR_BIT])
    else $error("clear without failure mode not aborted");

  chk_status_byte_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_o |-> !device_status_flags_o[ST_BUSY_BIT] && !device_status_flags_o[ST_FAULT_BIT]
      && !device_status_flags_o[ST_CORRECTED_BIT]
      && device_status_flags_o[ST_ERROR_BIT] == command_error_flags_o[ERR_ABORT_BIT])
    else $error("status byte bits wrong at completion");
endmodule

// ### testbench/host_adapter_model.sv
`timescale 1ns/100ps
module host_adapter_model
  import sanitize_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        done_i,
  input  wire logic [47:0] resp_i,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_opcode_o,
  output logic [15:0]      cmd_feature_o,
  output logic [15:0]      cmd_count_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_opcode_o = 8'h4B;
    cmd_feature_o = 16'hFFFF;
    cmd_count_o = 16'hFFFF;
  end

  // one command, then a bounded wait for done
  task automatic issue(input logic [15:0] feat, input logic [15:0] cnt,
                       output logic [47:0] resp, output logic seen);
    int i;
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_opcode_o = SANITIZE_OPCODE;
    cmd_feature_o = feat;
    cmd_count_o = cnt;
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b0;
    // released lines show no stale value
    cmd_opcode_o = ~SANITIZE_OPCODE;
    cmd_feature_o = ~feat;
    cmd_count_o = ~cnt;
    seen = 1'b0;
    for (i = 0; i < 4 && !seen; i++) begin
      if (done_i === 1'b1) begin
        seen = 1'b1;
      end else begin
        @(posedge clk_i);
        #1;
      end
    end
    resp = resp_i;
  endtask
endmodule

// ### testbench/sanitize_cmd_ctrl_tb.sv
`timescale 1ns/100ps
module sanitize_cmd_ctrl_tb;
  import sanitize_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i, hw_rst_i, keep_init_i;
  logic        op_begin_i, op_fail_mode_i, op_end_i, op_ok_i;
  logic [15:0] op_progress_i;
  logic        cmd_valid, done_o, frozen_o, seen;
  logic [7:0]  opcode, err, stat, sec, cyl;
  logic [15:0] feature, count, cnt;
  logic [47:0] got;
  wire  [47:0] resp = {err, stat, cnt, cyl, sec};
  int          error_cnt = 0;
  int          checks_done = 0;

  always #50 clk_i = ~clk_i;

  sanitize_cmd_ctrl sanitize_cmd_ctrl_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hw_rst_i(hw_rst_i),
    .keep_init_i(keep_init_i), .cmd_valid_i(cmd_valid), .cmd_opcode_i(opcode),
    .cmd_feature_i(feature), .cmd_count_i(count), .op_begin_i(op_begin_i),
    .op_fail_mode_i(op_fail_mode_i), .op_end_i(op_end_i), .op_ok_i(op_ok_i),
    .op_progress_i(op_progress_i), .done_o(done_o), .command_error_flags_o(err),
    .device_status_flags_o(stat), .count_out_o(cnt), .secnum_out_o(sec),
    .cyllow_out_o(cyl), .frozen_o(frozen_o));

  host_adapter_model host_adapter_model_inst (
    .clk_i(clk_i), .done_i(done_o), .resp_i(resp), .cmd_valid_o(cmd_valid),
    .cmd_opcode_o(opcode), .cmd_feature_o(feature), .cmd_count_o(count));

  function automatic logic [47:0] okr(input logic [15:0] c, input logic [15:0] p);
    return {ERR_RESET, STAT_RESET, c, p};
  endfunction

  function automatic logic [47:0] abr(input logic [15:0] c, input logic [7:0] hi,
                                      input logic [7:0] why);
    return {8'h04, 8'h51, c, hi, why};
  endfunction

  task automatic cmp_resp(input logic [48:0] g, input logic [48:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic run(input logic [15:0] f, input logic [15:0] c, input logic [47:0] e);
    host_adapter_model_inst.issue(f, c, got, seen);
    cmp_resp({seen, got}, {1'b1, e});
  endtask

  task automatic eng(input logic b, input logic fm, input logic e, input logic ok);
    @(posedge clk_i);
    #1;
    op_begin_i = b;
    op_fail_mode_i = fm;
    op_end_i = e;
    op_ok_i = ok;
    @(posedge clk_i);
    #1;
    op_begin_i = 1'b0;
    op_end_i = 1'b0;
  endtask

  task automatic rst(input logic hw);
    @(posedge clk_i);
    #1;
    hw_rst_i = hw;
    sys_rst_i = !hw;
    @(posedge clk_i);
    #1;
    hw_rst_i = 1'b0;
    sys_rst_i = 1'b0;
  endtask

  task automatic end_sim;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    error_cnt++;
    end_sim;
  end

  initial begin
    sys_rst_i = 1'b1;
    hw_rst_i = 1'b0;
    keep_init_i = 1'b1;
    op_begin_i = 1'b0;
    op_fail_mode_i = 1'b0;
    op_end_i = 1'b0;
    op_ok_i = 1'b0;
    op_progress_i = 16'h1234;
    repeat (12) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    keep_init_i = 1'b0;
    run(FEAT_STATUS, 16'h0000, okr(16'h0000, PROGRESS_IDLE));
    run(16'h0011, 16'h0000, abr(16'h0000, 8'hFF, REASON_BAD_FEATURE));
    eng(1'b1, 1'b1, 1'b0, 1'b0);
    run(FEAT_STATUS, 16'h0000, okr(16'h4000, 16'h1234));
    // freeze refused while running
    run(FEAT_FREEZE_LOCK, 16'h0000, abr(16'h4000, 8'h12, REASON_NONE));
    eng(1'b0, 1'b0, 1'b1, 1'b1);
    run(FEAT_STATUS, 16'h0000, okr(16'h8000, PROGRESS_IDLE));
    rst(1'b0);
    run(FEAT_STATUS, 16'h0000, okr(16'h8000, PROGRESS_IDLE));
    // freeze and start on one edge: frozen wins, bit 15 kept
    fork
      eng(1'b1, 1'b1, 1'b0, 1'b0);
      run(FEAT_FREEZE_LOCK, 16'h0000, okr(16'h8000, PROGRESS_IDLE));
    join
    run(FEAT_STATUS, 16'h0000, okr(16'hA000, PROGRESS_IDLE));
    rst(1'b1);
    eng(1'b1, 1'b1, 1'b0, 1'b0);
    eng(1'b0, 1'b0, 1'b1, 1'b0);
    run(FEAT_STATUS, 16'h0001, okr(16'h0000, PROGRESS_IDLE));
    eng(1'b1, 1'b0, 1'b0, 1'b0);
    eng(1'b0, 1'b0, 1'b1, 1'b0);
    run(FEAT_STATUS, 16'h0001, abr(16'h0000, 8'hFF, REASON_UNSANITIZED));
    run(FEAT_STATUS, 16'h0000, okr(16'h0000, PROGRESS_IDLE));
    rst(1'b0);
    run(FEAT_FREEZE_LOCK, 16'h0000, okr(16'h0000, PROGRESS_IDLE));
    cmp_bit(frozen_o, 1'b1);
    run(FEAT_STATUS, 16'h0000, okr(16'h2000, PROGRESS_IDLE));
    run(16'h0011, 16'h0000, abr(16'h2000, 8'hFF, REASON_FROZEN));
    run(FEAT_FREEZE_LOCK, 16'h0000, abr(16'h2000, 8'hFF, REASON_FROZEN));
    run(FEAT_STATUS, 16'h0001, okr(16'h2000, PROGRESS_IDLE));
    rst(1'b1);
    run(FEAT_STATUS, 16'h0000, okr(16'h0000, PROGRESS_IDLE));
    run(FEAT_FREEZE_LOCK, 16'h0000, okr(16'h0000, PROGRESS_IDLE));
    rst(1'b0);
    cmp_bit(frozen_o, 1'b0);
    run(FEAT_STATUS, 16'h0000, okr(16'h0000, PROGRESS_IDLE));
    end_sim;
  end
endmodule
